/* hdl/hrl_regs.svh */
`ifndef HRL_REGS_SVH
`define HRL_REGS_SVH

`define HRL_ADDR_REALTIME_SAMPLE 8'h02
`define HRL_ADDR_LIBRARY_FLOAT   8'h03
`define HRL_RST_REALTIME_SAMPLE  8'h00
`define HRL_RST_LIBRARY_FLOAT    8'h01
`define HRL_LIB_FLOAT_MASK       8'h17
`define HRL_FLOAT_BIT            4
`define HRL_LIB_SEL_MSB          2
`define HRL_LIB_SEL_LSB          0
`define HRL_MODE_DIRECT_DRIVE    3'h5
`define HRL_LIB_EMPTY_CODE       3'h0
`define HRL_LIB_LRA_CODE         3'h6
`define HRL_LIB_RESERVED_CODE    3'h7
`define HRL_SAMPLE_WIDTH         8
`define HRL_FIFO_DEPTH           16

`endif

/* hdl/hrl_pkg.sv */
`default_nettype none

package hrl_pkg;

    typedef enum logic [1:0] {
        HRL_LIB_EMPTY,
        HRL_LIB_ACTUATOR,
        HRL_LIB_LRA,
        HRL_LIB_RESERVED
    } hrl_lib_kind_t;

endpackage : hrl_pkg

`default_nettype wire

/* hdl/hrl_realtime_library.sv */
// Behaviour
// RQ1 - In mode 5 the engine keeps driving the load with the current sample.
// RQ2 - Sample writes are accepted any time during direct drive and applied each; code refuses them while the 16-entry FIFO is full.
// RQ3 - Sample is signed after reset, unsigned when the format bit is set.
// RQ4 - Host ends direct drive by writing mode 0 or setting standby.
// RQ5 - Library register bit 4 puts the output driver into high impedance.
// RQ6 - High impedance only applies while enabled, not in shutdown or standby.
// RQ7 - High impedance takes effect at once, even during a playback.
// RQ8 - Library select bits 2-0 are captured when playback is triggered.
// RQ9 - Select 0 empty, 1 to 5 actuator, 6 linear resonant, 7 reserved.
// RQ10 - Mode 5 drives the actuator from the sample register at address 0x02.
// RQ11 - Mode register bit 6 set means software standby, clear means ready.
// RQ12 - Signed samples are two's complement; register holds last written value; code keeps last accepted value, drops writes while FIFO is full.
`include "hrl_regs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Sample FIFO with a registered ready on the filling side.
module hrl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    // Filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = CW'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            count      <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wr_ptr     <= next_wr_ptr;
            rd_ptr     <= next_rd_ptr;
            count      <= next_count;
            in_ready_o <= (next_count != FULL_COUNT);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    a_fifo_no_overflow : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        count <= FULL_COUNT) else $error("fifo count above depth");

endmodule : hrl_fifo

////////////////////////////////////////////////////////////////////////////////

// Real-time sample and library/output-float registers with their playback taps.
module hrl_realtime_library (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    // Register port from the serial interface
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic                  reg_wr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_rd_i,
    output logic                       reg_wr_ready_o,
    output logic [7:0]                 reg_rdata_o,
    output logic                       reg_rvalid_o,
    // Device state from the mode and format registers
    input  wire logic [2:0]            mode_sel_i,
    input  wire logic                  standby_i,
    input  wire logic                  hw_enable_i,
    input  wire logic                  sample_sign_format_select_i,
    // Playback engine
    input  wire logic                  go_trigger_i,
    input  wire logic                  sample_take_i,
    output logic                       drive_active_o,
    output logic [7:0]                 drive_level_o,
    output logic                       output_float_enable_o,
    output logic [2:0]                 lib_select_o,
    output var hrl_pkg::hrl_lib_kind_t lib_kind_o,
    output logic                       lib_latched_o
);
    logic [7:0]             realtime_sample_value;
    logic [7:0]             library_and_output_float;
    logic [7:0]             drive_sample;
    logic [7:0]             next_realtime_sample_value;
    logic [7:0]             next_library_and_output_float;
    logic [7:0]             next_drive_sample;
    logic [7:0]             next_drive_level;
    logic [7:0]             next_rdata;
    logic                   next_rvalid;
    logic                   next_drive_active;
    logic                   next_float;
    logic [2:0]             next_lib_select;
    hrl_pkg::hrl_lib_kind_t next_lib_kind;
    logic                   next_lib_latched;
    logic                   sample_wr;
    logic                   lib_wr;
    logic                   sample_push;
    logic                   fifo_valid;
    logic                   fifo_take;
    logic [7:0]             fifo_data;
    logic                   direct_drive;
    logic                   device_enabled;

    ////////////////////////////////////////////////////////////////////////////

    // Register writes and reads.
    assign sample_wr   = reg_wr_i && (reg_addr_i == `HRL_ADDR_REALTIME_SAMPLE);
    assign lib_wr      = reg_wr_i && (reg_addr_i == `HRL_ADDR_LIBRARY_FLOAT);
    assign sample_push = sample_wr && reg_wr_ready_o;

    always_comb begin
        next_realtime_sample_value    = realtime_sample_value;
        next_library_and_output_float = library_and_output_float;
        if (sample_push) begin
            next_realtime_sample_value = reg_wdata_i; // RQ2
        end
        if (lib_wr) begin
            next_library_and_output_float = reg_wdata_i & `HRL_LIB_FLOAT_MASK;
        end
        next_rvalid = reg_rd_i;
        case (reg_addr_i)
            `HRL_ADDR_REALTIME_SAMPLE: next_rdata = realtime_sample_value;
            `HRL_ADDR_LIBRARY_FLOAT:   next_rdata = library_and_output_float;
            default:                   next_rdata = 8'h00;
        endcase
        if (!reg_rd_i) begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            realtime_sample_value    <= `HRL_RST_REALTIME_SAMPLE;
            library_and_output_float <= `HRL_RST_LIBRARY_FLOAT;
            reg_rdata_o              <= 8'h00;
            reg_rvalid_o             <= 1'b0;
        end else begin
            realtime_sample_value    <= next_realtime_sample_value; // RQ12
            library_and_output_float <= next_library_and_output_float;
            reg_rdata_o              <= next_rdata;
            reg_rvalid_o             <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Samples queue up so the host can stream faster than single writes.
    hrl_fifo #(
        .WIDTH (`HRL_SAMPLE_WIDTH),
        .DEPTH (`HRL_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (sample_wr),
        .in_ready_o  (reg_wr_ready_o),
        .in_data_i   (reg_wdata_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take),
        .out_data_o  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Direct drive path and output float control.
    assign device_enabled = hw_enable_i && !standby_i; // RQ11
    assign direct_drive   = (mode_sel_i == `HRL_MODE_DIRECT_DRIVE) && device_enabled; // RQ10
    assign fifo_take      = direct_drive && sample_take_i;

    always_comb begin
        next_drive_sample = drive_sample;
        if (fifo_take && fifo_valid) begin
            next_drive_sample = fifo_data; // RQ2
        end
        next_drive_active = direct_drive; // RQ1
        if (sample_sign_format_select_i) begin
            next_drive_level = {~drive_sample[7], drive_sample[6:0]}; // RQ3
        end else begin
            next_drive_level = drive_sample; // RQ12
        end
        next_float = library_and_output_float[`HRL_FLOAT_BIT] && device_enabled; // RQ5 RQ6
        if (lib_wr) begin
            next_float = reg_wdata_i[`HRL_FLOAT_BIT] && device_enabled; // RQ7
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            drive_sample          <= 8'h00;
            drive_active_o        <= 1'b0;
            drive_level_o         <= 8'h00;
            output_float_enable_o <= 1'b0;
        end else begin
            drive_sample          <= next_drive_sample;
            drive_active_o        <= next_drive_active;
            drive_level_o         <= next_drive_level;
            output_float_enable_o <= next_float;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Library capture on a playback trigger.
    always_comb begin
        next_lib_select  = lib_select_o;
        next_lib_kind    = lib_kind_o;
        next_lib_latched = go_trigger_i;
        if (go_trigger_i) begin
            next_lib_select = library_and_output_float[`HRL_LIB_SEL_MSB:`HRL_LIB_SEL_LSB]; // RQ8
            case (next_lib_select)
                `HRL_LIB_EMPTY_CODE:    next_lib_kind = hrl_pkg::HRL_LIB_EMPTY; // RQ9
                `HRL_LIB_LRA_CODE:      next_lib_kind = hrl_pkg::HRL_LIB_LRA;
                `HRL_LIB_RESERVED_CODE: next_lib_kind = hrl_pkg::HRL_LIB_RESERVED;
                default:                next_lib_kind = hrl_pkg::HRL_LIB_ACTUATOR;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            lib_select_o  <= 3'h1;
            lib_kind_o    <= hrl_pkg::HRL_LIB_ACTUATOR;
            lib_latched_o <= 1'b0;
        end else begin
            lib_select_o  <= next_lib_select;
            lib_kind_o    <= next_lib_kind;
            lib_latched_o <= next_lib_latched;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Checks.
    sequence s_push_accepted;
        sample_wr && reg_wr_ready_o;
    endsequence

    sequence s_take_then_level;
        fifo_take && fifo_valid ##1 !sample_sign_format_select_i;
    endsequence

    a_drive_active_mode : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ1
        ##1 drive_active_o == $past((mode_sel_i == 3'h5) && hw_enable_i && !standby_i))
        else $error("drive active does not follow mode 5");

    a_sample_store : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ2
        s_push_accepted |=> realtime_sample_value == $past(reg_wdata_i))
        else $error("accepted sample not stored");

    a_sample_hold : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ12
        !sample_push |=> $stable(realtime_sample_value))
        else $error("sample register changed without write");

    a_signed_level : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ3
        s_take_then_level |=> drive_level_o == $past(fifo_data, 2))
        else $error("signed sample not passed unchanged");

    a_unsigned_level : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ3
        sample_sign_format_select_i |=> drive_level_o == {~$past(drive_sample[7]),
                                                          $past(drive_sample[6:0])})
        else $error("unsigned sample not offset");

    a_float_fast : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ7
        lib_wr && reg_wdata_i[4] && hw_enable_i && !standby_i |=> output_float_enable_o)
        else $error("float not applied at once");

    a_float_disabled : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ6
        (standby_i || !hw_enable_i) |=> !output_float_enable_o)
        else $error("float while not enabled");

    a_lib_capture : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ8
        go_trigger_i |=> lib_latched_o && lib_select_o == $past(library_and_output_float[2:0])
        ##1 $stable(lib_select_o) || $past(go_trigger_i))
        else $error("library select not captured on trigger");

    a_lib_decode : assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RQ9
        lib_latched_o |-> (lib_select_o == 3'h6) == (lib_kind_o == hrl_pkg::HRL_LIB_LRA)
        && (lib_select_o == 3'h0) == (lib_kind_o == hrl_pkg::HRL_LIB_EMPTY)
        && (lib_select_o == 3'h7) == (lib_kind_o == hrl_pkg::HRL_LIB_RESERVED))
        else $error("library kind decode wrong");

endmodule : hrl_realtime_library

`default_nettype wire

/* tb/hrl_host_model.sv */
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Host that drives the register strobe port and the mode register fields.
module hrl_host_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Register port
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i,
    // Mode register fields
    output logic [2:0]      mode_sel_o,
    output logic            standby_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
        mode_sel_o = 3'h0;
        standby_o = 1'b0;
    end

    // One write strobe; released data shows its inverse.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask : wr

    // One read strobe; the answer is taken in the cycle after.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(negedge clk_sys_i);
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        data = reg_rdata_i;
        vld = reg_rvalid_i;
    endtask : rd

    // Mode 0 or standby ends direct drive.
    task automatic set_mode(input logic [2:0] mode, input logic stby);
        @(negedge clk_sys_i);
        mode_sel_o = mode;
        standby_o = stby;
    endtask : set_mode
endmodule : hrl_host_model

`default_nettype wire

/* tb/hrl_realtime_library_tb.sv */
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module hrl_realtime_library_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_sys_i = 1'b0;
    logic                   sys_rst_i = 1'b1;
    logic [7:0]             addr, wdata, rdata, level, d;
    logic                   wr, rd, ready, rvalid, act, flt, latched, v;
    logic [2:0]             mode, lib_sel;
    logic                   stby;
    logic                   hw_en = 1'b1;
    logic                   fmt = 1'b0;
    logic                   go = 1'b0;
    logic                   take = 1'b0;
    hrl_pkg::hrl_lib_kind_t kind;
    int                     fails = 0;
    int                     n_tests = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    hrl_host_model u_host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .mode_sel_o(mode), .standby_o(stby));

    hrl_realtime_library u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_wr_ready_o(ready), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .mode_sel_i(mode), .standby_i(stby), .hw_enable_i(hw_en),
        .sample_sign_format_select_i(fmt), .go_trigger_i(go), .sample_take_i(take),
        .drive_active_o(act), .drive_level_o(level), .output_float_enable_o(flt),
        .lib_select_o(lib_sel), .lib_kind_o(kind), .lib_latched_o(latched));

    task automatic stop_test();
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    task automatic take_chk(input logic [7:0] exp);
        take = 1'b1;
        @(negedge clk_sys_i);
        take = 1'b0;
        cyc(2);
        chk(level, exp);
    endtask : take_chk

    function automatic hrl_pkg::hrl_lib_kind_t exp_kind(input int c);
        if (c == 0) return hrl_pkg::HRL_LIB_EMPTY;
        if (c == 6) return hrl_pkg::HRL_LIB_LRA;
        if (c == 7) return hrl_pkg::HRL_LIB_RESERVED;
        return hrl_pkg::HRL_LIB_ACTUATOR;
    endfunction : exp_kind

    initial begin : watchdog
        #100000;
        fails++;
        stop_test();
    end

    initial begin : main
        cyc(5);
        sys_rst_i = 1'b0;
        rdchk(8'h02, 8'h00);
        rdchk(8'h03, 8'h01);
        rdchk(8'h05, 8'h00);
        chk({5'h00, lib_sel}, 8'h01);
        chk({7'h00, flt}, 8'h00);
        chk({7'h00, act}, 8'h00);
        u_host.wr(8'h03, 8'hff);
        chk({7'h00, flt}, 8'h01);
        rdchk(8'h03, 8'h17);
        u_host.set_mode(3'h0, 1'b1);
        cyc(1);
        chk({7'h00, flt}, 8'h00);
        u_host.set_mode(3'h0, 1'b0);
        cyc(1);
        chk({7'h00, flt}, 8'h01);
        hw_en = 1'b0;
        cyc(1);
        chk({7'h00, flt}, 8'h00);
        hw_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            u_host.wr(8'h03, 8'(i));
            go = 1'b1;
            @(negedge clk_sys_i);
            go = 1'b0;
            chk({7'h00, latched}, 8'h01);
            chk({5'h00, lib_sel}, 8'(i));
            chk({6'h00, kind}, {6'h00, exp_kind(i)});
        end
        u_host.wr(8'h03, 8'h06);
        cyc(1);
        chk({5'h00, lib_sel}, 8'h07);
        u_host.set_mode(3'h5, 1'b0);
        cyc(1);
        chk({7'h00, act}, 8'h01);
        u_host.wr(8'h02, 8'h10);
        take_chk(8'h10);
        fmt = 1'b1;
        cyc(2);
        chk(level, 8'h90);
        u_host.wr(8'h02, 8'h80);
        take_chk(8'h00);
        fmt = 1'b0;
        cyc(2);
        chk(level, 8'h80);
        u_host.set_mode(3'h0, 1'b0);
        cyc(1);
        chk({7'h00, act}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            u_host.wr(8'h02, 8'h20 + 8'(i));
        end
        cyc(1);
        chk({7'h00, ready}, 8'h00);
        take_chk(8'h80);
        u_host.wr(8'h02, 8'hee);
        rdchk(8'h02, 8'h2f);
        u_host.set_mode(3'h5, 1'b0);
        for (int i = 0; i < 16; i++) begin
            take_chk(8'h20 + 8'(i));
        end
        take_chk(8'h2f);
        chk({7'h00, ready}, 8'h01);
        u_host.set_mode(3'h5, 1'b1);
        cyc(1);
        chk({7'h00, act}, 8'h00);
        stop_test();
    end
endmodule : hrl_realtime_library_tb

`default_nettype wire
